// >>> src/imp_pkg.sv
// Constants and types of the interrupt mask, priority and power block
//
// Contract
// R1 - Enable bit 7 gates all sources; at 0 nothing requests.
// R2 - Enable bit 4 masks serial port requests.
// R3 - Enable bit 3 masks timer one, bit 1 timer zero overflow.
// R4 - Enable bit 2 masks external line one, bit 0 line zero.
// R5 - Enable bits 6 and 5 read zero, ignore writes; reset all zero.
// R6 - Priority bits 4..0 pick high level per source; 1 is high.
// R7 - Priority bits 7..5 read 100, ignore writes; reset 0x80.
// R8 - Extended enable one bit 1 masks USB; rest zero; reset zero.
// R9 - Extended priority one bit 1 sets USB level; rest read zero.
// R10 - Extended enable two bit 0 masks VBUS sense; others read zero.
// R11 - Extended priority two bit 0 sets VBUS level; reset zero.
// R12 - Writing idle bit halts CPU after the write; clocks keep running.
// R13 - Idle keeps every register unchanged; peripherals may run.
// R14 - Enabled interrupt in idle clears idle and resumes the CPU.
// R15 - After the wake service returns, code continues after idle write.
// R16 - Reset during idle runs normal reset, start at zero.
// R17 - Writing stop bit stops oscillator, CPU and digital peripherals.
// R18 - Stop leaves low frequency oscillator alone; no interrupts in stop.
// R19 - Only a reset leaves stop, then normal reset sequence.
// R20 - Missing clock detector resets and ends stop; disable it first.
// R21 - Suspend holds oscillator off until USB event or VBUS match.
// R22 - High level preempts low service; high service is never preempted.
// R23 - High level first; ties by fixed order ext0 first, VBUS last.
// R24 - Idle and stop bits always read back zero.
// R25 - Request only when pending, mask and global gate all set.
package imp_pkg;
    localparam logic [7:0] IMP_ADDR_INT_EN = 8'ha8;
    localparam logic [7:0] IMP_ADDR_INT_PRIO = 8'hb8;
    localparam logic [7:0] IMP_ADDR_EXT_EN_ONE = 8'he6;
    localparam logic [7:0] IMP_ADDR_EXT_PRIO_ONE = 8'hf6;
    localparam logic [7:0] IMP_ADDR_EXT_EN_TWO = 8'hf7;
    localparam logic [7:0] IMP_ADDR_EXT_PRIO_TWO = 8'hf7;
    localparam logic [7:0] IMP_ADDR_PWR_CTRL = 8'h87;
    localparam int IMP_GATE_BIT = 7;
    localparam int IMP_USB_BIT = 1;
    localparam int IMP_VBUS_BIT = 0;
    localparam int IMP_IDLE_BIT = 0;
    localparam int IMP_STOP_BIT = 1;
    localparam logic [7:0] IMP_INT_EN_RST = 8'h00;
    localparam logic [7:0] IMP_INT_PRIO_RST = 8'h80;
    localparam logic [2:0] IMP_INT_PRIO_FIXED = 3'h4;
    localparam logic [7:0] IMP_EXT_RST = 8'h00;
    localparam logic [7:0] IMP_PWR_CTRL_RST = 8'h00;
    localparam int IMP_NUM_SRC = 7;

    typedef enum logic [2:0] {
        SRC_EXT0 = 3'h0,
        SRC_TMR0 = 3'h1,
        SRC_EXT1 = 3'h2,
        SRC_TMR1 = 3'h3,
        SRC_SERIAL = 3'h4,
        SRC_USB = 3'h5,
        SRC_VBUS = 3'h6
    } imp_src_t;

    typedef enum logic [1:0] {
        PM_RUN = 2'h0,
        PM_IDLE = 2'h1,
        PM_STOP = 2'h2
    } imp_pm_t;

    typedef struct packed {
        logic req;
        logic high;
        imp_src_t src;
    } imp_irq_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } imp_sfr_t;
endpackage

// >>> src/imp_ctrl.sv
// Interrupt mask, priority arbitration and idle/stop power control
`timescale 1ns/1ps
module imp_ctrl (
    input logic sys_clk_i,
    input logic rst_b_i,
    input imp_pkg::imp_sfr_t sfr_i,
    output logic [7:0] sfr_rdata_o,
    input logic [imp_pkg::IMP_NUM_SRC-1:0] pend_i,
    input logic irq_ack_i,
    input logic return_from_interrupt_i,
    input logic suspend_req_i,
    input logic usb_event_i,
    input logic vbus_level_i,
    input logic bus_power_polarity_select_i,
    output imp_pkg::imp_irq_t irq_o,
    output logic cpu_halt_o,
    output logic osc_stop_o
);
    import imp_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic global_irq_gate;
    logic [4:0] int_en_mask;
    logic [4:0] int_prio_level;
    logic usb_function_irq_mask;
    logic usb_function_irq_level;
    logic bus_power_sense_irq_mask;
    logic bus_power_sense_irq_level;
    logic [5:0] pwr_ctrl_flags;
    imp_pm_t pm_state;
    imp_pm_t next_pm;
    logic svc_low;
    logic svc_high;
    logic suspended;
    logic next_suspended;
    imp_irq_t next_irq;
    logic [7:0] next_rdata;
    logic [IMP_NUM_SRC-1:0] mask_vec;
    logic [IMP_NUM_SRC-1:0] level_vec;
    logic [IMP_NUM_SRC-1:0] active;
    logic [IMP_NUM_SRC-1:0] hi_cand;
    logic [IMP_NUM_SRC-1:0] lo_cand;
    logic wr_int_en;
    logic wr_int_prio;
    logic wr_ext_en_one;
    logic wr_ext_prio_one;
    logic wr_ext_en_two;
    logic wr_ext_prio_two;
    logic wr_pwr_ctrl;
    logic vbus_match;

    // Lowest index wins within one level
    function automatic imp_src_t first_set(
        input logic [IMP_NUM_SRC-1:0] v
    );
        imp_src_t s;
        s = SRC_EXT0;
        for (int i = IMP_NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                s = imp_src_t'(i[2:0]);
            end
        end
        return s;
    endfunction

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    assign wr_int_en = sfr_i.wr && (sfr_i.addr == IMP_ADDR_INT_EN);
    assign wr_int_prio = sfr_i.wr && (sfr_i.addr == IMP_ADDR_INT_PRIO);
    assign wr_ext_en_one = sfr_i.wr && (sfr_i.addr == IMP_ADDR_EXT_EN_ONE);
    assign wr_ext_prio_one = sfr_i.wr &&
        (sfr_i.addr == IMP_ADDR_EXT_PRIO_ONE);
    assign wr_ext_en_two = sfr_i.wr && (sfr_i.addr == IMP_ADDR_EXT_EN_TWO);
    assign wr_ext_prio_two = sfr_i.wr &&
        (sfr_i.addr == IMP_ADDR_EXT_PRIO_TWO);
    assign wr_pwr_ctrl = sfr_i.wr && (sfr_i.addr == IMP_ADDR_PWR_CTRL);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            global_irq_gate <= IMP_INT_EN_RST[IMP_GATE_BIT];
            int_en_mask <= IMP_INT_EN_RST[4:0];
        end else if (wr_int_en) begin
            global_irq_gate <= sfr_i.wdata[IMP_GATE_BIT]; // R1
            int_en_mask <= sfr_i.wdata[4:0]; // R2 R3 R4 R5
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_prio_level <= IMP_INT_PRIO_RST[4:0];
        end else if (wr_int_prio) begin
            int_prio_level <= sfr_i.wdata[4:0]; // R6 R7
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            usb_function_irq_mask <= IMP_EXT_RST[IMP_USB_BIT];
            usb_function_irq_level <= IMP_EXT_RST[IMP_USB_BIT];
            bus_power_sense_irq_mask <= IMP_EXT_RST[IMP_VBUS_BIT];
            bus_power_sense_irq_level <= IMP_EXT_RST[IMP_VBUS_BIT];
        end else begin
            if (wr_ext_en_one) begin
                usb_function_irq_mask <= sfr_i.wdata[IMP_USB_BIT]; // R8
            end
            if (wr_ext_prio_one) begin
                usb_function_irq_level <= sfr_i.wdata[IMP_USB_BIT]; // R9
            end
            if (wr_ext_en_two) begin
                bus_power_sense_irq_mask <= sfr_i.wdata[IMP_VBUS_BIT]; // R10
            end
            // Shares its address with the enable, so both update together
            if (wr_ext_prio_two) begin
                bus_power_sense_irq_level <= sfr_i.wdata[IMP_VBUS_BIT]; // R11
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pwr_ctrl_flags <= IMP_PWR_CTRL_RST[7:2];
        end else if (wr_pwr_ctrl) begin
            pwr_ctrl_flags <= sfr_i.wdata[7:2];
        end
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the address
    // ------------------------------------------------------------
    always_comb begin
        case (sfr_i.addr)
            IMP_ADDR_INT_EN: begin
                next_rdata = {global_irq_gate, 2'h0, int_en_mask}; // R5
            end
            IMP_ADDR_INT_PRIO: begin
                next_rdata = {IMP_INT_PRIO_FIXED, int_prio_level}; // R7
            end
            IMP_ADDR_EXT_EN_ONE: begin
                next_rdata = {6'h00, usb_function_irq_mask, 1'b0}; // R8
            end
            IMP_ADDR_EXT_PRIO_ONE: begin
                next_rdata = {6'h00, usb_function_irq_level, 1'b0}; // R9
            end
            IMP_ADDR_EXT_EN_TWO: begin
                next_rdata = {7'h00, bus_power_sense_irq_mask}; // R10
            end
            IMP_ADDR_PWR_CTRL: begin
                next_rdata = {pwr_ctrl_flags, 2'h0}; // R24
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sfr_rdata_o <= 8'h00;
        end else begin
            sfr_rdata_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Masking and arbitration
    // ------------------------------------------------------------
    assign mask_vec = {bus_power_sense_irq_mask, usb_function_irq_mask,
                       int_en_mask};
    assign level_vec = {bus_power_sense_irq_level, usb_function_irq_level,
                        int_prio_level};
    assign active = pend_i & mask_vec & {IMP_NUM_SRC{global_irq_gate}}; // R25 R1
    assign hi_cand = active & level_vec; // R6
    assign lo_cand = active & ~level_vec;

    always_comb begin
        next_irq.req = 1'b0;
        next_irq.high = 1'b0;
        next_irq.src = SRC_EXT0;
        if (pm_state == PM_STOP) begin
            next_irq.req = 1'b0; // R18
        end else if (!svc_high && (|hi_cand)) begin
            next_irq.req = 1'b1; // R22 R23
            next_irq.high = 1'b1;
            next_irq.src = first_set(hi_cand);
        end else if (!svc_high && !svc_low && (|lo_cand)) begin
            next_irq.req = 1'b1; // R22 R23
            next_irq.src = first_set(lo_cand);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= '0;
        end else begin
            irq_o <= next_irq;
        end
    end

    // Service levels; an acknowledge in the return_from_interrupt cycle still sets
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            svc_low <= 1'b0;
            svc_high <= 1'b0;
        end else begin
            if (return_from_interrupt_i) begin
                if (svc_high) begin
                    svc_high <= 1'b0;
                end else begin
                    svc_low <= 1'b0;
                end
            end
            if (irq_ack_i && irq_o.req) begin
                if (irq_o.high) begin
                    svc_high <= 1'b1; // R22
                end else begin
                    svc_low <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------
    always_comb begin
        next_pm = pm_state;
        case (pm_state)
            PM_RUN: begin
                if (wr_pwr_ctrl && sfr_i.wdata[IMP_STOP_BIT]) begin
                    next_pm = PM_STOP; // R17
                end else if (wr_pwr_ctrl && sfr_i.wdata[IMP_IDLE_BIT]) begin
                    next_pm = PM_IDLE; // R12
                end
            end
            PM_IDLE: begin
                // Registers hold; the CPU resumes where it halted
                if (|active) begin
                    next_pm = PM_RUN; // R13 R14 R15
                end
            end
            PM_STOP: begin
                next_pm = PM_STOP; // R19 R20
            end
            default: begin
                next_pm = PM_RUN;
            end
        endcase
    end

    // Any reset returns to run with all registers at reset values
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pm_state <= PM_RUN; // R16 R19
        end else begin
            pm_state <= next_pm;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cpu_halt_o <= 1'b0;
        end else begin
            cpu_halt_o <= (next_pm != PM_RUN); // R12 R17
        end
    end

    assign vbus_match = (vbus_level_i == bus_power_polarity_select_i);

    always_comb begin
        next_suspended = suspended;
        if (suspended && (usb_event_i || vbus_match)) begin
            next_suspended = 1'b0; // R21
        end else if (suspend_req_i) begin
            next_suspended = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            suspended <= 1'b0;
        end else begin
            suspended <= next_suspended;
        end
    end

    // Only the internal oscillator stops; the slow one is untouched
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            osc_stop_o <= 1'b0;
        end else begin
            osc_stop_o <= (next_pm == PM_STOP) || next_suspended; // R17 R18 R21
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_gate_blocks_req: assert property ( // R1
        !global_irq_gate |=> !irq_o.req
    ) else $error("request without global gate");

    a_mask_serial_src: assert property ( // R2
        irq_o.req && irq_o.src == SRC_SERIAL |-> $past(int_en_mask[4])
    ) else $error("serial request while masked");

    a_en_unused_zero: assert property ( // R5
        sfr_i.addr == IMP_ADDR_INT_EN |=> sfr_rdata_o[6:5] == 2'h0
    ) else $error("enable bits 6:5 not zero");

    a_prio_top_pattern: assert property ( // R7
        sfr_i.addr == IMP_ADDR_INT_PRIO |=> sfr_rdata_o[7:5] == 3'h4
    ) else $error("priority top bits not 100");

    a_pwr_mode_zero: assert property ( // R24
        sfr_i.addr == IMP_ADDR_PWR_CTRL |=> sfr_rdata_o[1:0] == 2'h0
    ) else $error("idle or stop bit read back");

    a_idle_entry_halt: assert property ( // R12
        pm_state == PM_RUN && wr_pwr_ctrl && sfr_i.wdata[1:0] == 2'h1
        |=> pm_state == PM_IDLE && cpu_halt_o
    ) else $error("idle not entered");

    a_idle_wake_run: assert property ( // R14
        pm_state == PM_IDLE && (|active) |=> pm_state == PM_RUN && !cpu_halt_o
    ) else $error("enabled interrupt did not wake");

    a_stop_held_quiet: assert property ( // R19
        pm_state == PM_STOP |=> pm_state == PM_STOP && osc_stop_o
        ##1 !irq_o.req
    ) else $error("stop left or request in stop");

    a_high_no_preempt: assert property ( // R22
        svc_high |=> !irq_o.req
    ) else $error("high service preempted");

    a_high_first_pick: assert property ( // R23
        pm_state != PM_STOP && !svc_high && (|hi_cand) |=> irq_o.high
        && (($past(hi_cand) >> irq_o.src) & 7'h01) == 7'h01
        && ($past(hi_cand) & ((7'h01 << irq_o.src) - 7'h01)) == 7'h00
    ) else $error("wrong arbitration winner");

    c_idle_wake: cover property (
        pm_state == PM_IDLE ##1 pm_state == PM_RUN
    );
    c_stop_entry: cover property (
        pm_state == PM_RUN ##1 pm_state == PM_STOP
    );
    c_preempt_low: cover property (
        svc_low && !svc_high ##1 irq_o.req && irq_o.high
    );
endmodule

// >>> verification/imp_cpu_model.sv
// CPU model that vectors to presented requests and returns from service
`timescale 1ns/1ps
module imp_cpu_model (
    input logic sys_clk_i,
    input logic rst_b_i,
    input imp_pkg::imp_irq_t irq_i,
    input logic ack_cmd_i,
    input logic slow_i,
    input logic return_cmd_i,
    output logic irq_ack_o,
    output logic return_from_interrupt_o
);
    import imp_pkg::*;
    logic [1:0] dly;
    // Vectors only to a standing request; slow mode stalls 3 cycles
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_ack_o <= 1'b0;
            dly <= 2'h0;
        end else if (ack_cmd_i && irq_i.req && !irq_ack_o) begin
            if (!slow_i || dly == 2'h3) begin
                irq_ack_o <= 1'b1;
                dly <= 2'h0;
            end else begin
                dly <= dly + 2'h1;
            end
        end else begin
            irq_ack_o <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            return_from_interrupt_o <= 1'b0;
        end else begin
            return_from_interrupt_o <= return_cmd_i;
        end
    end
endmodule

// >>> verification/imp_ctrl_tb.sv
// Self-checking bench for the interrupt mask, priority and power block
`timescale 1ns/1ps
module imp_ctrl_tb;
    import imp_pkg::*;
    logic sys_clk, rst_b, ack_cmd, slow, ret_cmd, irq_ack, ret_pulse;
    logic susp_req, usb_ev, vbus, vb_pol, halt, osc;
    imp_sfr_t sfr;
    imp_irq_t irq;
    logic [7:0] rdata;
    logic [6:0] pend;
    int fail_count = 0;
    int cmp_count = 0;

    imp_ctrl dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .sfr_i(sfr),
        .sfr_rdata_o(rdata), .pend_i(pend), .irq_ack_i(irq_ack),
        .return_from_interrupt_i(ret_pulse), .suspend_req_i(susp_req),
        .usb_event_i(usb_ev),
        .vbus_level_i(vbus), .bus_power_polarity_select_i(vb_pol),
        .irq_o(irq), .cpu_halt_o(halt), .osc_stop_o(osc));
    imp_cpu_model cpu (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .irq_i(irq),
        .ack_cmd_i(ack_cmd), .slow_i(slow), .return_cmd_i(ret_cmd),
        .irq_ack_o(irq_ack), .return_from_interrupt_o(ret_pulse));

    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk_irq(logic r, logic h, logic [2:0] s);
        chk("irq", r ? {3'h0, irq} : {7'h0, irq.req}, {3'h0, r, h, s});
    endtask
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic setp(logic [6:0] v);
        @(posedge sys_clk);
        pend <= v;
        settle();
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        sfr <= '{addr: a, wr: 1'b1, wdata: d};
        @(posedge sys_clk);
        sfr.wr <= 1'b0;
    endtask
    task automatic rd(string n, logic [7:0] a, logic [7:0] e);
        @(posedge sys_clk);
        sfr.addr <= a;
        @(posedge sys_clk);
        #1;
        chk(n, rdata, e);
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
    endtask
    task automatic ack(logic sl);
        @(posedge sys_clk);
        slow <= sl;
        ack_cmd <= 1'b1;
        for (int i = 0; i < 10 && irq_ack !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (irq_ack !== 1'b1) begin
            fail_count++;
            summarize();
        end
        @(posedge sys_clk);
        ack_cmd <= 1'b0;
        settle();
    endtask
    task automatic ret();
        @(posedge sys_clk);
        ret_cmd <= 1'b1;
        @(posedge sys_clk);
        ret_cmd <= 1'b0;
        settle();
    endtask
    task automatic en(int s, logic g, logic on);
        wr(IMP_ADDR_INT_EN, {g, 2'h0, (s < 5 && on) ? (5'h1 << s) : 5'h0});
        wr(IMP_ADDR_EXT_EN_ONE, {6'h0, s == 5 && on, 1'b0});
        wr(IMP_ADDR_EXT_EN_TWO, {7'h0, s == 6 && on});
    endtask
    task automatic susp();
        @(posedge sys_clk);
        susp_req <= 1'b1;
        @(posedge sys_clk);
        susp_req <= 1'b0;
        settle();
        chk("osc", osc, 1);
    endtask

    //--------------------------------------------
    // Scenarios
    //--------------------------------------------
    task automatic t_regs();
        logic [7:0] a [5];
        logic [7:0] r [5];
        logic [7:0] f [5];
        a = '{IMP_ADDR_INT_EN, IMP_ADDR_INT_PRIO, IMP_ADDR_EXT_EN_ONE,
              IMP_ADDR_EXT_PRIO_ONE, IMP_ADDR_EXT_EN_TWO};
        r = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
        f = '{8'h9f, 8'h9f, 8'h02, 8'h02, 8'h01};
        for (int i = 0; i < 5; i++) begin
            rd("reset", a[i], r[i]);
            wr(a[i], 8'hff);
            rd("ones", a[i], f[i]);
            wr(a[i], 8'h00);
            rd("zeros", a[i], r[i]);
        end
        wr(8'h55, 8'hff);
        rd("unmapped", 8'h55, 8'h00);
        wr(IMP_ADDR_PWR_CTRL, 8'hfc);
        rd("pwr_ctrl", IMP_ADDR_PWR_CTRL, 8'hfc);
        wr(IMP_ADDR_PWR_CTRL, 8'h00);
    endtask
    task automatic t_mask();
        for (int s = 0; s < 7; s++) begin
            @(posedge sys_clk);
            pend <= 7'h1 << s;
            en(s, 1'b0, 1'b1);
            settle();
            chk_irq(0, 0, 0);
            en(s, 1'b1, 1'b0);
            settle();
            chk_irq(0, 0, 0);
            en(s, 1'b1, 1'b1);
            settle();
            chk_irq(1, s == 6, s[2:0]);
        end
        en(0, 1'b0, 1'b0);
    endtask
    task automatic t_prio();
        wr(IMP_ADDR_INT_EN, 8'h9f);
        wr(IMP_ADDR_EXT_EN_ONE, 8'h02);
        setp(7'h3e);
        chk_irq(1, 0, 1);
        wr(IMP_ADDR_INT_PRIO, 8'h10);
        settle();
        chk_irq(1, 1, 4);
        wr(IMP_ADDR_INT_PRIO, 8'h00);
        wr(IMP_ADDR_EXT_PRIO_ONE, 8'h02);
        settle();
        chk_irq(1, 1, 5);
        wr(IMP_ADDR_EXT_PRIO_ONE, 8'h00);
        setp(7'h01);
        chk_irq(1, 0, 0);
        ack(1'b0);
        chk_irq(0, 0, 0);
        wr(IMP_ADDR_INT_PRIO, 8'h10);
        setp(7'h11);
        chk_irq(1, 1, 4);
        ack(1'b1);
        chk_irq(0, 0, 0);
        ret();
        chk_irq(1, 1, 4);
    endtask
    task automatic t_power();
        do_reset();
        setp(7'h00);
        wr(IMP_ADDR_INT_EN, 8'h81);
        wr(IMP_ADDR_PWR_CTRL, 8'h01);
        settle();
        chk("halt", halt, 1);
        rd("pwr_ctrl", IMP_ADDR_PWR_CTRL, 8'h00);
        rd("keep", IMP_ADDR_INT_EN, 8'h81);
        setp(7'h02);
        chk("halt", halt, 1);
        setp(7'h01);
        chk("halt", halt, 0);
        chk_irq(1, 0, 0);
        setp(7'h00);
        wr(IMP_ADDR_PWR_CTRL, 8'h02);
        settle();
        chk("halt", halt, 1);
        chk("osc", osc, 1);
        setp(7'h01);
        chk_irq(0, 0, 0);
        chk("halt", halt, 1);
        setp(7'h00);
        do_reset();
        settle();
        chk("halt", halt, 0);
        chk("osc", osc, 0);
        rd("reset", IMP_ADDR_INT_EN, 8'h00);
    endtask
    task automatic t_susp();
        susp();
        @(posedge sys_clk);
        usb_ev <= 1'b1;
        settle();
        chk("osc", osc, 0);
        @(posedge sys_clk);
        usb_ev <= 1'b0;
        susp();
        @(posedge sys_clk);
        vbus <= 1'b1;
        settle();
        chk("osc", osc, 0);
        @(posedge sys_clk);
        vb_pol <= 1'b0;
        susp();
        @(posedge sys_clk);
        vbus <= 1'b0;
        settle();
        chk("osc", osc, 0);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        rst_b = 1'b0;
        sfr = '0;
        pend = 7'h00;
        ack_cmd = 1'b0;
        slow = 1'b0;
        ret_cmd = 1'b0;
        susp_req = 1'b0;
        usb_ev = 1'b0;
        vbus = 1'b0;
        vb_pol = 1'b1;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_regs();
        t_mask();
        t_prio();
        t_power();
        t_susp();
        summarize();
    end
endmodule
